/* File: rtl/mrc_top.sv */
`timescale 1ns/100ps
module mrc_top import mrc_pkg::*; (
  input wire logic CLK, // 100 MHz clock
  input wire logic RESETN, // async reset, low
  input wire logic RAW_VALID, // new converter reading
  input wire mrc_val_t RAW_DATA, // converter reading
  input wire mrc_val_t RANGE_LO, // input range lower limit
  input wire mrc_val_t RANGE_HI, // input range upper limit
  input wire logic CUSTOM_TC, // custom thermocouple selected
  input wire logic CUSTOM_SENSOR, // any custom sensor type
  input wire logic signed [15:0] CJ_TEMP, // junction temp, 0.1 C
  input wire logic [15:0] ICE_SLOPE, // slope, 0.01 uV/C
  input wire logic [4:0] POINT_COUNT, // scaling points
  input wire logic [3:0] PT_IDX, // point being keyed in
  input wire mrc_val_t PT_VALUE, // keyed-in value
  input wire logic PT_WR_INPUT, // store keyed input value
  input wire logic PT_WR_DISPLAY, // store keyed display value
  input wire logic STYLE_SET_APPLY, // start apply pass
  input wire logic CAPTURE_KEY, // store live input as point
  input wire logic SKIP_KEY, // skip point without storing
  input wire logic [7:0] FILT_TC, // filter constant, 0.1 s
  input wire logic [7:0] FILT_BAND, // filter band
  input wire logic [7:0] ROUND_INC, // rounding increment
  input wire logic OFFSET_WR, // load offset
  input wire mrc_val_t OFFSET_IN, // offset to load
  input wire logic ZERO_CMD, // zero the display
  input wire logic [2:0] DP_SEL, // display decimal point
  input wire logic [2:0] TOT_DP_SEL, // totalizer decimal point
  input wire logic TEMP_SCALE_SEL, // temperature scale
  output mrc_val_t DISP_VALUE, // displayed value
  output logic DISP_VALID, // new display value pulse
  output mrc_val_t OFFSET_VALUE, // stored offset
  output logic STYLE_APPLY, // apply style active
  output logic [3:0] APPLY_INDEX, // apply pass point
  output logic [2:0] DISP_DP, // display decimal point
  output logic [2:0] TOT_DP, // totalizer decimal point
  output logic TEMP_SCALE, // scale for all readouts
  output logic SCALE_VISIBLE, // scale option offered
  output logic BUSY // reading in progress
);
  function automatic mrc_val_t sat(input logic signed [47:0] v);
    if (v > 48'(VAL_MAX)) begin
      return VAL_MAX;
    end else if (v < 48'(VAL_MIN)) begin
      return VAL_MIN;
    end
    return v[23:0];
  endfunction

  // ************************************************************
  // point memory
  // ************************************************************
  mrc_val_t rd_in;
  mrc_val_t rd_disp;
  logic [3:0] mem_ra;
  logic we_in;
  logic [3:0] wa_in;
  mrc_val_t wd_in;
  logic we_disp;

  mrc_point_mem u_mem (
    .clk(CLK),
    .resetn(RESETN),
    .we_in(we_in),
    .wa_in(wa_in),
    .wd_in(wd_in),
    .we_disp(we_disp),
    .wa_disp(PT_IDX),
    .wd_disp(sat(48'(PT_VALUE))), // RL22
    .ra(mem_ra),
    .rd_in_ff(rd_in),
    .rd_disp_ff(rd_disp)
  );

  logic [4:0] cnt_n;
  always_comb begin
    cnt_n = POINT_COUNT;
    if (POINT_COUNT < PTS_MIN) begin
      cnt_n = PTS_MIN; // RL13
    end else if (POINT_COUNT > PTS_MAX) begin
      cnt_n = PTS_MAX; // RL13
    end
  end

  // ************************************************************
  // reading pipeline
  // ************************************************************
  mrc_state_t st_ff, nxt_st;
  mrc_phase_t ph_ff, nxt_ph;
  mrc_val_t x_ff, nxt_x, lo_in_ff, nxt_lo_in, lo_d_ff, nxt_lo_d, y_ff, nxt_y;
  mrc_val_t disp_ff, nxt_disp;
  logic [3:0] idx_ff, nxt_idx;
  logic [47:0] dvd_ff, nxt_dvd;
  logic [23:0] dvs_ff, nxt_dvs;
  logic [24:0] rem_ff, nxt_rem;
  logic [5:0] dcnt_ff, nxt_dcnt;
  logic neg_ff, nxt_neg, first_ff, nxt_first, valid_ff, nxt_valid;
  logic signed [39:0] acc_ff, nxt_acc;
  mrc_val_t offset_ff;
  logic [7:0] tc_c, band_c;

  assign tc_c = (FILT_TC > TC_MAX) ? TC_MAX : FILT_TC; // RL6
  assign band_c = (FILT_BAND > BAND_MAX) ? BAND_MAX : FILT_BAND; // RL9

  always_comb begin
    logic [15:0] slope;
    logic signed [32:0] prod;
    logic signed [32:0] comp;
    logic signed [33:0] xs;
    logic signed [24:0] dx, dd, den;
    logic signed [49:0] num;
    logic [24:0] rsh;
    logic ge;
    logic signed [47:0] q;
    logic signed [40:0] diff;
    logic signed [58:0] fprod;
    logic signed [24:0] dev;
    logic byp;
    mrc_val_t v;
    logic [47:0] r;
    slope = (ICE_SLOPE > SLOPE_MAX) ? SLOPE_MAX : ICE_SLOPE;
    prod = 33'sh0;
    comp = 33'sh0;
    xs = 34'sh0;
    dx = 25'sh0;
    dd = 25'sh0;
    den = 25'sh0;
    num = 50'sh0;
    rsh = 25'h0;
    ge = 1'b0;
    q = 48'sh0;
    diff = 41'sh0;
    fprod = 59'sh0;
    dev = 25'sh0;
    byp = 1'b0;
    v = 24'sh0;
    r = 48'h0;
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_x = x_ff;
    nxt_lo_in = lo_in_ff;
    nxt_lo_d = lo_d_ff;
    nxt_y = y_ff;
    nxt_disp = disp_ff;
    nxt_idx = idx_ff;
    nxt_dvd = dvd_ff;
    nxt_dvs = dvs_ff;
    nxt_rem = rem_ff;
    nxt_dcnt = dcnt_ff;
    nxt_neg = neg_ff;
    nxt_first = first_ff;
    nxt_acc = acc_ff;
    nxt_valid = 1'b0;
    unique case (st_ff)
      S_IDLE: begin
        if (RAW_VALID) begin
          if (CUSTOM_TC && slope != 16'h0000) begin
            // slope is 0.01 uV/C and temp 0.1 C, so 1000 gives uV
            prod = 33'($signed({1'b0, slope})) * 33'(CJ_TEMP); // RL11
            comp = prod / 33'(ICE_DIV); // RL11
          end // RL12
          xs = 34'(RAW_DATA) + 34'(comp);
          nxt_x = xs[23:0];
          if (xs < 34'(RANGE_LO)) begin
            nxt_x = RANGE_LO; // RL15
          end else if (xs > 34'(RANGE_HI)) begin
            nxt_x = RANGE_HI; // RL15
          end
          nxt_idx = 4'h0;
          nxt_st = S_LO;
        end
      end
      S_LO: begin
        nxt_lo_in = rd_in;
        nxt_lo_d = rd_disp;
        nxt_idx = 4'h1;
        nxt_st = S_HI;
      end
      S_HI: begin
        // outer segments are used beyond the end points
        if (x_ff < rd_in || {1'b0, idx_ff} == cnt_n - 5'd1) begin
          dx = 25'(x_ff) - 25'(lo_in_ff); // RL14
          dd = 25'(rd_disp) - 25'(lo_d_ff); // RL14
          den = 25'(rd_in) - 25'(lo_in_ff); // RL14
          num = 50'(dx) * 50'(dd);
          nxt_neg = num[49] ^ den[24];
          nxt_dvd = 48'h0;
          nxt_dvs = den[24] ? 24'(-den) : den[23:0];
          nxt_rem = 25'h0;
          nxt_dcnt = 6'h0;
          nxt_ph = PH_INTERP;
          if (den == 25'sh0 || num == 50'sh0) begin
            nxt_neg = 1'b0; // a vertical segment shows its first display value
            nxt_st = S_SCALED;
          end else begin
            nxt_dvd = num[49] ? 48'(-num) : num[47:0];
            nxt_st = S_DIV;
          end
        end else begin
          nxt_lo_in = rd_in; // RL14
          nxt_lo_d = rd_disp;
          nxt_idx = idx_ff + 4'h1;
        end
      end
      S_DIV: begin
        rsh = {rem_ff[23:0], dvd_ff[47]};
        ge = rsh >= {1'b0, dvs_ff};
        nxt_rem = ge ? rsh - {1'b0, dvs_ff} : rsh;
        nxt_dvd = {dvd_ff[46:0], ge};
        nxt_dcnt = dcnt_ff + 6'h1;
        if (dcnt_ff == DIV_STEPS - 6'h1) begin
          unique case (ph_ff)
            PH_INTERP: nxt_st = S_SCALED;
            PH_ALPHA: nxt_st = S_FILT;
            PH_ROUND: nxt_st = S_ROUND;
            default: nxt_st = S_IDLE;
          endcase
        end
      end
      S_SCALED: begin
        q = neg_ff ? -$signed(dvd_ff) : $signed(dvd_ff);
        nxt_y = sat(48'(lo_d_ff) + q); // RL14
        nxt_st = S_FILT;
        if (tc_c != 8'h00 && !first_ff) begin
          // gain = Ts / (Ts + tau), tau chosen so three constants give 99%
          nxt_dvd = {8'h00, TS_X100, 16'h0000}; // RL7
          nxt_dvs = TS_X100 + 24'(TAU_K * 24'(tc_c)); // RL7
          nxt_rem = 25'h0;
          nxt_dcnt = 6'h0;
          nxt_ph = PH_ALPHA;
          nxt_st = S_DIV;
        end
      end
      S_FILT: begin
        dev = 25'(y_ff) - 25'($signed(acc_ff[39:16]));
        if (dev[24]) begin
          dev = -dev;
        end
        byp = first_ff || tc_c == 8'h00; // RL8
        if (band_c != 8'h00 && dev > 25'(band_c)) begin
          byp = 1'b1; // RL9
        end // RL10
        if (byp) begin
          nxt_acc = $signed({y_ff, 16'h0000});
        end else begin
          diff = 41'($signed({y_ff, 16'h0000})) - 41'(acc_ff); // RL23
          fprod = 59'(diff) * 59'($signed({1'b0, dvd_ff[16:0]})); // RL23
          nxt_acc = acc_ff + 40'(fprod >>> FW); // RL23
        end
        nxt_first = 1'b0;
        v = sat(48'(nxt_acc >>> FW) + 48'(offset_ff)); // RL4
        if (ROUND_INC > ROUND_ONE) begin
          // rounding works on the displayed units, from the lowest digit up
          nxt_neg = v[23];
          nxt_dvd = 48'(v[23] ? -v : v) + 48'(ROUND_INC[7:1]); // RL2
          nxt_dvs = 24'(ROUND_INC);
          nxt_rem = 25'h0;
          nxt_dcnt = 6'h0;
          nxt_ph = PH_ROUND;
          nxt_st = S_DIV;
        end else begin
          nxt_disp = v;
          nxt_valid = 1'b1;
          nxt_st = S_IDLE;
        end
      end
      S_ROUND: begin
        r = 48'(dvd_ff * 48'(ROUND_INC)); // RL1
        nxt_disp = sat(neg_ff ? -$signed(r) : $signed(r)); // RL1
        nxt_valid = 1'b1;
        nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
    if (ZERO_CMD) begin
      nxt_disp = 24'sh000000; // RL5
    end
  end

  assign mem_ra = nxt_idx;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_ff <= S_IDLE;
      ph_ff <= PH_INTERP;
      x_ff <= 24'sh0;
      lo_in_ff <= 24'sh0;
      lo_d_ff <= 24'sh0;
      y_ff <= 24'sh0;
      disp_ff <= 24'sh0;
      idx_ff <= 4'h0;
      dvd_ff <= 48'h0;
      dvs_ff <= 24'h0;
      rem_ff <= 25'h0;
      dcnt_ff <= 6'h0;
      neg_ff <= 1'b0;
      first_ff <= 1'b1;
      acc_ff <= 40'sh0;
      valid_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      x_ff <= nxt_x;
      lo_in_ff <= nxt_lo_in;
      lo_d_ff <= nxt_lo_d;
      y_ff <= nxt_y;
      disp_ff <= nxt_disp;
      idx_ff <= nxt_idx;
      dvd_ff <= nxt_dvd;
      dvs_ff <= nxt_dvs;
      rem_ff <= nxt_rem;
      dcnt_ff <= nxt_dcnt;
      neg_ff <= nxt_neg;
      first_ff <= nxt_first;
      acc_ff <= nxt_acc;
      valid_ff <= nxt_valid;
    end
  end

  // ************************************************************
  // configuration and scaling entry
  // ************************************************************
  logic style_ff, nxt_style, scale_ff, nxt_scale, vis_ff, nxt_vis, busy_ff, nxt_busy;
  logic [3:0] aidx_ff, nxt_aidx;
  logic [2:0] dp_ff, nxt_dp, tdp_ff, nxt_tdp;
  mrc_val_t nxt_offset;

  always_comb begin
    logic signed [47:0] osum;
    logic [2:0] dp_max;
    osum = 48'sh0;
    nxt_offset = offset_ff;
    nxt_style = style_ff;
    nxt_aidx = aidx_ff;
    we_in = PT_WR_INPUT;
    wa_in = PT_IDX;
    wd_in = sat(48'(PT_VALUE)); // RL18
    if (OFFSET_WR) begin
      nxt_offset = sat(48'(OFFSET_IN)); // RL4
    end
    if (ZERO_CMD) begin
      osum = 48'(offset_ff) - 48'(disp_ff); // RL5
      nxt_offset = sat(osum); // RL5
    end
    if (STYLE_SET_APPLY && !CUSTOM_SENSOR) begin
      nxt_style = 1'b1;
      nxt_aidx = 4'h0;
    end else if (style_ff && (CAPTURE_KEY || SKIP_KEY)) begin
      if (CAPTURE_KEY && !SKIP_KEY) begin
        we_in = 1'b1;
        wa_in = aidx_ff;
        wd_in = sat(48'(x_ff)); // RL18
      end // RL17
      nxt_aidx = aidx_ff + 4'h1;
      if ({1'b0, aidx_ff} == cnt_n - 5'd1) begin
        nxt_style = 1'b0; // RL16
        nxt_aidx = 4'h0;
      end
    end
    // custom sensors have no scale choice but one more decimal place
    dp_max = CUSTOM_SENSOR ? DP_MAX_CUST : DP_MAX_STD; // RL21
    nxt_dp = (DP_SEL > dp_max) ? dp_max : DP_SEL; // RL19
    nxt_tdp = TOT_DP_SEL; // RL19
    nxt_vis = !CUSTOM_SENSOR; // RL21
    nxt_scale = CUSTOM_SENSOR ? scale_ff : TEMP_SCALE_SEL; // RL20
    nxt_busy = nxt_st != S_IDLE;
  end

  assign we_disp = PT_WR_DISPLAY; // RL3

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      offset_ff <= OFFSET_RST;
      style_ff <= 1'b0;
      aidx_ff <= 4'h0;
      dp_ff <= DP_RST;
      tdp_ff <= DP_RST;
      scale_ff <= 1'b0;
      vis_ff <= 1'b1;
      busy_ff <= 1'b0;
    end else begin
      offset_ff <= nxt_offset;
      style_ff <= nxt_style;
      aidx_ff <= nxt_aidx;
      dp_ff <= nxt_dp;
      tdp_ff <= nxt_tdp;
      scale_ff <= nxt_scale;
      vis_ff <= nxt_vis;
      busy_ff <= nxt_busy;
    end
  end

  assign DISP_VALUE = disp_ff;
  assign DISP_VALID = valid_ff;
  assign OFFSET_VALUE = offset_ff;
  assign STYLE_APPLY = style_ff;
  assign APPLY_INDEX = aidx_ff;
  assign DISP_DP = dp_ff;
  assign TOT_DP = tdp_ff;
  assign TEMP_SCALE = scale_ff;
  assign SCALE_VISIBLE = vis_ff;
  assign BUSY = busy_ff;
endmodule

/* File: inc/mrc_pkg.sv */
// Overview of operation
// RL1 - round display to nearest selected increment
// RL2 - rounding acts from least significant digit
// RL3 - rounding change leaves stored points untouched
// RL4 - add signed offset, -19999 to 99999
// RL5 - zero command rewrites offset; zero offset neutral
// RL6 - filter constant in tenths, 0.0 to 25.0
// RL7 - step reaches 99% in three constants
// RL8 - zero constant bypasses the filter
// RL9 - filter disengages outside band, up to 250
// RL10 - zero band keeps filter always engaged
// RL11 - custom thermocouple ice slope, 0 to 650.00
// RL12 - zero slope turns compensation off
// RL13 - two to sixteen scaling points supported
// RL14 - interpolate between adjacent programmed points
// RL15 - extrapolate outer segments up to range limits
// RL16 - apply pass ends, style returns to key-in
// RL17 - skip key advances point without storing
// RL18 - input values limited to -19999 to 99999
// RL19 - display point shared, totalizer point separate
// RL20 - one temperature scale for all readouts
// RL21 - custom sensor hides scale, widens point choice
// RL22 - display values limited to -19999 to 99999
// RL23 - first-order fixed-point update per reading
package mrc_pkg;
  localparam int VW = 24;
  localparam int FW = 16;
  typedef logic signed [VW-1:0] mrc_val_t;
  localparam mrc_val_t VAL_MIN = -24'sd19999;
  localparam mrc_val_t VAL_MAX = 24'sd99999;
  localparam logic [7:0] TC_MAX = 8'd250;
  localparam logic [7:0] BAND_MAX = 8'd250;
  localparam logic [15:0] SLOPE_MAX = 16'd65000;
  localparam logic [4:0] PTS_MIN = 5'd2;
  localparam logic [4:0] PTS_MAX = 5'd16;
  localparam logic [7:0] ROUND_ONE = 8'd1;
  localparam logic [2:0] DP_MAX_STD = 3'd3;
  localparam logic [2:0] DP_MAX_CUST = 3'd4;
  localparam mrc_val_t OFFSET_RST = 24'sh000000;
  localparam logic [2:0] DP_RST = 3'd0;
  // ************************************************************
  // filter timing
  // ************************************************************
  localparam int SAMPLE_MS = 50;
  localparam int TC_UNIT_MS = 100;
  localparam int SETTLE_TC = 3;
  localparam int SETTLE_LN_X1000 = 4605;
  localparam logic [23:0] TS_X100 = 24'(SAMPLE_MS * 100);
  localparam logic [23:0] TAU_K = 24'(TC_UNIT_MS * SETTLE_TC * 100000 / SETTLE_LN_X1000);
  localparam int ICE_DIV = 1000;
  localparam logic [5:0] DIV_STEPS = 6'd48;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_LO = 7'h02,
    S_HI = 7'h04,
    S_DIV = 7'h08,
    S_SCALED = 7'h10,
    S_FILT = 7'h20,
    S_ROUND = 7'h40
  } mrc_state_t;
  typedef enum logic [1:0] {
    PH_INTERP = 2'h0,
    PH_ALPHA = 2'h1,
    PH_ROUND = 2'h2
  } mrc_phase_t;
endpackage

/* File: rtl/mrc_point_mem.sv */
`timescale 1ns/100ps
module mrc_point_mem import mrc_pkg::*; (
  input wire logic clk, // clock
  input wire logic resetn, // async reset, low
  input wire logic we_in, // write input value
  input wire logic [3:0] wa_in, // input value address
  input wire mrc_val_t wd_in, // input value data
  input wire logic we_disp, // write display value
  input wire logic [3:0] wa_disp, // display value address
  input wire mrc_val_t wd_disp, // display value data
  input wire logic [3:0] ra, // read address
  output mrc_val_t rd_in_ff, // registered input value
  output mrc_val_t rd_disp_ff // registered display value
);
  mrc_val_t in_mem_ff [16];
  mrc_val_t disp_mem_ff [16];
  mrc_val_t nxt_in_mem [16];
  mrc_val_t nxt_disp_mem [16];

  always_comb begin
    nxt_in_mem = in_mem_ff;
    nxt_disp_mem = disp_mem_ff;
    if (we_in) begin
      nxt_in_mem[wa_in] = wd_in;
    end
    if (we_disp) begin
      nxt_disp_mem[wa_disp] = wd_disp;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        in_mem_ff[i] <= 24'sh000000;
        disp_mem_ff[i] <= 24'sh000000;
      end
      rd_in_ff <= 24'sh000000;
      rd_disp_ff <= 24'sh000000;
    end else begin
      in_mem_ff <= nxt_in_mem;
      disp_mem_ff <= nxt_disp_mem;
      rd_in_ff <= in_mem_ff[ra];
      rd_disp_ff <= disp_mem_ff[ra];
    end
  end
endmodule

/* File: tb/mrc_assertions.sv */
`timescale 1ns/100ps
module mrc_assertions import mrc_pkg::*; (
  input wire logic CLK, // clock
  input wire logic RESETN, // reset, low
  input wire logic RAW_VALID, // reading
  input wire logic CUSTOM_SENSOR, // custom
  input wire logic [4:0] POINT_COUNT, // points
  input wire logic STYLE_SET_APPLY, // apply
  input wire logic CAPTURE_KEY, // capture
  input wire logic SKIP_KEY, // skip
  input wire logic OFFSET_WR, // load
  input wire mrc_val_t OFFSET_IN, // offset in
  input wire logic ZERO_CMD, // zero
  input wire logic [2:0] DP_SEL, // point
  input wire logic [2:0] TOT_DP_SEL, // point
  input wire logic TEMP_SCALE_SEL, // scale
  input wire mrc_val_t DISP_VALUE, // display
  input wire logic DISP_VALID, // strobe
  input wire mrc_val_t OFFSET_VALUE, // offset
  input wire logic STYLE_APPLY, // apply on
  input wire logic [3:0] APPLY_INDEX, // index
  input wire logic [2:0] DISP_DP, // point
  input wire logic [2:0] TOT_DP, // point
  input wire logic TEMP_SCALE, // scale
  input wire logic SCALE_VISIBLE, // shown
  input wire logic BUSY // busy
);
  logic [2:0] dp_lim;
  logic [4:0] last_idx;
  logic keyed;
  assign dp_lim = CUSTOM_SENSOR ? DP_MAX_CUST : DP_MAX_STD;
  assign last_idx = (POINT_COUNT < PTS_MIN ? PTS_MIN : (POINT_COUNT > PTS_MAX ? PTS_MAX : POINT_COUNT)) - 5'h01;
  assign keyed = STYLE_APPLY && (CAPTURE_KEY || SKIP_KEY) && !STYLE_SET_APPLY;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ************************************************************
  // checks
  // ************************************************************
  take_busy_a: assert property (RAW_VALID && !BUSY |=> BUSY) else $error("reading not taken");
  result_due_a: assert property ($rose(BUSY) |-> ##[1:200] DISP_VALID) else $error("no result");
  valid_pulse_a: assert property (DISP_VALID |=> !DISP_VALID) else $error("strobe too long");
  disp_range_a: assert property (DISP_VALID |-> DISP_VALUE >= VAL_MIN && DISP_VALUE <= VAL_MAX)
    else $error("display out of range");
  zero_disp_a: assert property (ZERO_CMD && !BUSY |=> DISP_VALUE == '0) else $error("zero ignored");
  offset_load_a: assert property (OFFSET_WR && !ZERO_CMD && OFFSET_IN >= VAL_MIN && OFFSET_IN <= VAL_MAX
    |=> OFFSET_VALUE == $past(OFFSET_IN)) else $error("offset not loaded");
  apply_block_a: assert property (STYLE_SET_APPLY && CUSTOM_SENSOR && !STYLE_APPLY |=> !STYLE_APPLY)
    else $error("apply on custom");
  apply_step_a: assert property (keyed && {1'b0, APPLY_INDEX} < last_idx
    |=> STYLE_APPLY && APPLY_INDEX == $past(APPLY_INDEX) + 4'h1) else $error("apply step");
  apply_end_a: assert property (keyed && {1'b0, APPLY_INDEX} == last_idx
    |=> !STYLE_APPLY && APPLY_INDEX == 4'h0) else $error("apply end");
  dp_clamp_a: assert property (1'b1 |=> DISP_DP == ($past(DP_SEL) > $past(dp_lim) ? $past(dp_lim) : $past(DP_SEL)))
    else $error("display point");
  tot_dp_a: assert property (1'b1 |=> TOT_DP == $past(TOT_DP_SEL)) else $error("total point");
  scale_hide_a: assert property (1'b1 |=> SCALE_VISIBLE == !$past(CUSTOM_SENSOR)) else $error("scale shown");
  scale_all_a: assert property (!CUSTOM_SENSOR |=> TEMP_SCALE == $past(TEMP_SCALE_SEL)) else $error("scale");
  cover property (DISP_VALID);
  cover property (ZERO_CMD && !BUSY);
  cover property (keyed && {1'b0, APPLY_INDEX} == last_idx);
endmodule

bind mrc_top mrc_assertions i_mrc_assertions (.*);

/* File: tb/mrc_adc_model.sv */
`timescale 1ns/100ps
module mrc_adc_model import mrc_pkg::*; (
  input wire logic clk, // clock
  input wire logic resetn, // reset, low
  input wire logic go, // start conversion
  input wire mrc_val_t value, // reading to send
  input wire logic [3:0] gap, // conversion delay
  input wire logic busy, // block busy
  output logic raw_valid, // reading strobe
  output mrc_val_t raw_data // reading
);
  logic pend;
  logic [3:0] cnt;
  mrc_val_t hold;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {pend, raw_valid, cnt} <= '0;
      raw_data <= '0;
      hold <= '0;
    end else begin
      raw_valid <= 1'b0;
      // stale data must never look like a valid reading
      if (raw_valid) begin
        raw_data <= ~raw_data;
      end
      if (go) begin
        pend <= 1'b1;
        cnt <= gap;
        hold <= value;
      end else if (pend && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend && !busy) begin
        raw_valid <= 1'b1;
        raw_data <= hold;
        pend <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/mrc_top_tb.sv */
`timescale 1ns/100ps
module mrc_top_tb import mrc_pkg::*;;
  logic CLK, RESETN, RAW_VALID, CUSTOM_TC, CUSTOM_SENSOR, PT_WR_INPUT, PT_WR_DISPLAY, STYLE_SET_APPLY;
  logic CAPTURE_KEY, SKIP_KEY, OFFSET_WR, ZERO_CMD, TEMP_SCALE_SEL, go;
  logic DISP_VALID, STYLE_APPLY, TEMP_SCALE, SCALE_VISIBLE, BUSY;
  mrc_val_t RAW_DATA, RANGE_LO, RANGE_HI, PT_VALUE, OFFSET_IN, val, DISP_VALUE, OFFSET_VALUE;
  logic signed [15:0] CJ_TEMP;
  logic [15:0] ICE_SLOPE;
  logic [4:0] POINT_COUNT;
  logic [3:0] PT_IDX, gap, APPLY_INDEX;
  logic [7:0] FILT_TC, FILT_BAND, ROUND_INC;
  logic [2:0] DP_SEL, TOT_DP_SEL, DISP_DP, TOT_DP;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int rv[6] = '{122, 123, 7, -15, 4, 123};
  int ri[6] = '{5, 5, 2, 10, 0, 1};
  localparam int K_OFF = 0, K_ZERO = 1, K_SKIP = 2, K_CAP = 3, K_APPLY = 4;

  mrc_top i_mrc_top (.*);
  mrc_adc_model i_mrc_adc_model (.clk(CLK), .resetn(RESETN), .go, .value(val), .gap, .busy(BUSY),
    .raw_valid(RAW_VALID), .raw_data(RAW_DATA));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic mrc_val_t lin(int x, int x0, int d0, int x1, int d1);
    return mrc_val_t'(d0 + (x - x0) * (d1 - d0) / (x1 - x0));
  endfunction
  // nearest multiple, halves away from zero
  function automatic mrc_val_t rnd(int v, int inc);
    int q;
    if (inc < 2) return mrc_val_t'(v);
    q = (v < 0 ? -v : v) + inc / 2;
    q = q / inc * inc;
    return mrc_val_t'(v < 0 ? -q : q);
  endfunction
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0d seen %0d", n, $signed(e), $signed(g));
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic kick(input int w);
    @(posedge CLK);
    {STYLE_SET_APPLY, CAPTURE_KEY, SKIP_KEY, ZERO_CMD, OFFSET_WR} <= 5'(1 << w);
    @(posedge CLK);
    {STYLE_SET_APPLY, CAPTURE_KEY, SKIP_KEY, ZERO_CMD, OFFSET_WR} <= 5'h00;
    @(posedge CLK);
    #1;
  endtask
  task automatic set_pt(input logic [3:0] i, input mrc_val_t x, input mrc_val_t d);
    @(posedge CLK);
    PT_IDX <= i;
    PT_VALUE <= x;
    PT_WR_INPUT <= 1'b1;
    @(posedge CLK);
    PT_WR_INPUT <= 1'b0;
    PT_VALUE <= d;
    PT_WR_DISPLAY <= 1'b1;
    @(posedge CLK);
    PT_WR_DISPLAY <= 1'b0;
  endtask
  // one reading through the converter model, waits for the result strobe
  task automatic rd(input mrc_val_t v, input mrc_val_t e, input string n, input bit c = 1'b1);
    int k;
    @(posedge CLK);
    val <= v;
    gap <= 4'($urandom_range(0, 3));
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    for (k = 0; k < 300 && DISP_VALID !== 1'b1; k++) begin
      @(posedge CLK);
      #1;
    end
    chk("disp_valid", 1'b1, DISP_VALID);
    if (c) chk(n, e, DISP_VALUE);
  endtask

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int r;
    int lim;
    {CUSTOM_TC, CUSTOM_SENSOR, PT_WR_INPUT, PT_WR_DISPLAY, STYLE_SET_APPLY, CAPTURE_KEY} = '0;
    {SKIP_KEY, OFFSET_WR, ZERO_CMD, TEMP_SCALE_SEL, go, RESETN} = '0;
    {CJ_TEMP, ICE_SLOPE, PT_IDX, gap, FILT_TC, FILT_BAND, DP_SEL, TOT_DP_SEL, PT_VALUE, OFFSET_IN, val} = '0;
    RANGE_LO = VAL_MIN;
    RANGE_HI = VAL_MAX;
    POINT_COUNT = 5'h02;
    ROUND_INC = 8'h01;
    void'($urandom(32'h3930));
    repeat (3) @(posedge CLK);
    #1;
    chk("reset_scale_vis", 1'b1, SCALE_VISIBLE);
    chk("reset_offset", 24'h000000, OFFSET_VALUE);
    @(posedge CLK);
    RESETN <= 1'b1;
    set_pt(0, 0, 0);
    set_pt(1, 100, 200);
    rd(50, lin(50, 0, 0, 100, 200), "interp");
    rd(300, lin(300, 0, 0, 100, 200), "extrap_hi");
    rd(-50, lin(-50, 0, 0, 100, 200), "extrap_lo");
    RANGE_HI <= 24'sh0000fa;
    rd(300, lin(250, 0, 0, 100, 200), "range_limit");
    RANGE_HI <= VAL_MAX;
    POINT_COUNT <= 5'h03;
    set_pt(2, 200, 300);
    rd(150, lin(150, 100, 200, 200, 300), "segment_two");
    rd(400, lin(400, 100, 200, 200, 300), "extrap_last");
    set_pt(1, 1000, 1000);
    set_pt(2, 2000, 2000);
    CUSTOM_TC <= 1'b1;
    CJ_TEMP <= 16'sh00fa;
    ICE_SLOPE <= 16'h0064;
    rd(100, 125, "ice_comp");
    ICE_SLOPE <= 16'h0000;
    rd(100, 100, "ice_off");
    ICE_SLOPE <= SLOPE_MAX;
    CJ_TEMP <= 16'sh000a;
    rd(0, 650, "ice_max");
    CUSTOM_TC <= 1'b0;
    rd(0, 0, "ice_fixed");
    OFFSET_IN <= 24'sh000007;
    kick(K_OFF);
    chk("offset_load", 24'h000007, OFFSET_VALUE);
    rd(100, 107, "offset_add");
    kick(K_ZERO);
    chk("zero_disp", 24'h000000, DISP_VALUE);
    chk("zero_offset", -24'sd100, OFFSET_VALUE);
    rd(300, 200, "zero_shift");
    OFFSET_IN <= 24'sh018894;
    kick(K_OFF);
    chk("offset_limit", VAL_MAX, OFFSET_VALUE);
    OFFSET_IN <= 24'sh000000;
    kick(K_OFF);
    rd(300, 300, "offset_zero");
    foreach (rv[i]) begin
      ROUND_INC <= 8'(ri[i]);
      rd(rv[i], rnd(rv[i], ri[i]), "round");
    end
    for (int i = 0; i < 20; i++) begin
      r = $urandom_range(0, 1999);
      DP_SEL <= 3'($urandom);
      TOT_DP_SEL <= 3'($urandom);
      TEMP_SCALE_SEL <= 1'($urandom);
      CUSTOM_SENSOR <= 1'($urandom);
      rd(r, r, "random_read");
      lim = CUSTOM_SENSOR ? 4 : 3;
      chk("disp_dp", DP_SEL > lim ? lim : DP_SEL, DISP_DP);
      chk("tot_dp", TOT_DP_SEL, TOT_DP);
      chk("scale_vis", !CUSTOM_SENSOR, SCALE_VISIBLE);
    end
    CUSTOM_SENSOR <= 1'b1;
    kick(K_APPLY);
    chk("apply_blocked", 1'b0, STYLE_APPLY);
    CUSTOM_SENSOR <= 1'b0;
    kick(K_APPLY);
    chk("apply_on", 1'b1, STYLE_APPLY);
    rd(400, 400, "apply_live");
    kick(K_CAP);
    chk("apply_idx", 4'h1, APPLY_INDEX);
    kick(K_SKIP);
    chk("skip_idx", 4'h2, APPLY_INDEX);
    rd(2000, 2000, "apply_last");
    kick(K_CAP);
    chk("apply_off", 1'b0, STYLE_APPLY);
    rd(700, lin(700, 400, 0, 1000, 1000), "apply_points");
    set_pt(0, 0, 0);
    FILT_TC <= 8'h0a;
    FILT_BAND <= BAND_MAX;
    rd(5000, 5000, "band_out");
    rd(5100, 0, "band_in", 1'b0);
    chk("band_in", 1'b1, DISP_VALUE > 5000 && DISP_VALUE < 5100);
    FILT_BAND <= 8'h00;
    for (int i = 1; i <= 60; i++) begin
      rd(15000, 0, "step", 1'b0);
      if (i == 1) chk("band_zero", 1'b1, DISP_VALUE < 15000);
      if (i == 20) chk("one_tc", 1'b1, DISP_VALUE < 14000);
      if (i == 60) chk("three_tc", 1'b1, DISP_VALUE >= 14750);
    end
    FILT_TC <= 8'h00;
    rd(777, 777, "filter_off");
    give_verdict();
  end
endmodule
